// file: design/mdc_pkg.sv
// Shared constants and types of the multichannel transfer engine.
package mdc_pkg;
  // Register index inside one channel's window; byte address is ch*32 + idx*4.
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_REQ  = 3'h1;
  localparam logic [2:0] R_STA  = 3'h2;
  localparam logic [2:0] R_STB  = 3'h3;
  localparam logic [2:0] R_PAD  = 3'h4;
  localparam logic [2:0] R_CNT  = 3'h5;
  localparam int CH_LSB = 5;
  localparam int RG_LSB = 2;
  // Fields of channel_control.
  localparam int B_EN   = 15;
  localparam int B_SIZE = 14;
  localparam int B_DIR  = 13;
  localparam int B_HALF = 12;
  localparam int B_NULL = 11;
  localparam int AM_LSB = 4;
  localparam int MD_LSB = 0;
  localparam logic [15:0] CTRL_MASK = 16'hf833;
  // Fields of channel_request_select.
  localparam int B_FORCE = 15;
  localparam int SEL_W   = 7;
  // Addressing modes.
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_FIX = 2'h1;
  localparam logic [1:0] AM_PER = 2'h2;
  // Operating mode bits: bit 1 ping-pong, bit 0 one-shot.
  localparam int MD_PP  = 1;
  localparam int MD_ONE = 0;
  localparam int CNT_W      = 10;
  localparam int DONE_W     = 11;
  localparam int MAX_CH     = 8;
  localparam logic [15:0] RST_VAL   = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_CAP, ST_WR} mdc_state_t;
endpackage : mdc_pkg

// file: design/mdc_dma.sv
// Multichannel transfer engine between peripheral registers and the data RAM.
`timescale 1ns/100ps
`default_nettype none
module mdc_dma #(
  parameter int NCH = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Peripheral requests and indirect address
  input  wire logic [127:0] irq_req,
  input  wire logic [15:0]  ind_addr,
  // Data RAM port
  output logic [15:0]      ram_addr,
  output logic             ram_re,
  output logic             ram_we,
  output logic             ram_byte,
  output logic [15:0]      ram_wdata,
  input  wire logic [15:0] ram_rdata,
  // Peripheral data port
  output logic [15:0]      per_addr,
  output logic             per_re,
  output logic             per_we,
  output logic             per_byte,
  output logic [15:0]      per_wdata,
  input  wire logic [15:0] per_rdata,
  // Block events
  output logic [NCH-1:0]   block_irq
);
  import mdc_pkg::*;

  if (NCH < 1 || NCH > MAX_CH) begin : g_chk
    $error("mdc_dma: NCH must be 1 to 8");
  end

  logic [15:0]       ctrl     [NCH];
  logic [SEL_W-1:0]  sel      [NCH];
  logic [15:0]       sta      [NCH];
  logic [15:0]       stb      [NCH];
  logic [15:0]       pad      [NCH];
  logic [CNT_W-1:0]  cnt      [NCH];
  logic [15:0]       last_off [NCH];
  logic [15:0]       nxt_off  [NCH];
  logic [DONE_W-1:0] done_n   [NCH];
  logic [NCH-1:0]    force_b;
  logic [NCH-1:0]    force_clr;
  logic [NCH-1:0]    off_req;
  logic [NCH-1:0]    pp_sel;
  logic [NCH-1:0]    en_q;
  logic [NCH-1:0]    pend;
  logic [NCH-1:0]    en;
  logic [NCH-1:0]    pe;
  mdc_state_t        state;
  logic [2:0]        gnt;
  logic              gforce;
  logic [15:0]       gaddr;
  logic              wr_p;
  logic [7:0]        wa;
  logic              take;
  logic              wr_hit;
  logic [2:0]        wc;
  logic [2:0]        pk;

  // Lowest set bit wins.
  function automatic logic [2:0] pick(input logic [NCH-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : pick

  // Memory address for the next element of channel c.
  function automatic logic [15:0] mem_addr(input logic [2:0] c);
    logic [15:0] base;
    base = pp_sel[c] ? stb[c] : sta[c];
    if (ctrl[c][AM_LSB+:2] == AM_PER) begin
      return base + ind_addr;
    end
    return nxt_off[c];
  endfunction : mem_addr

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [2:0] c;
    c = a[CH_LSB+:3];
    if (a[1:0] != 2'h0 || int'(c) >= NCH) begin
      return 32'h0000_0000;
    end
    unique case (a[RG_LSB+:3])
      R_CTRL: return {16'h0000, ctrl[c]};
      R_REQ:  return {16'h0000, force_b[c], 8'h00, sel[c]};
      R_STA, R_STB: return {16'h0000, last_off[c]};
      R_PAD:  return {16'h0000, pad[c]};
      R_CNT:  return {22'h000000, cnt[c]};
      default: return 32'h0000_0000;
    endcase
  endfunction : rd_val

  assign take   = hsel & htrans[1] & hready;
  assign wc     = wa[CH_LSB+:3];
  assign wr_hit = wr_p && (int'(wc) < NCH) && (wa[1:0] == 2'h0);
  assign pk     = pick(pe);

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      en[c] = ctrl[c][B_EN];
    end
    pe = pend & en;
  end

  // Zero-wait slave; read data is fetched in the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_p      <= 1'b0;
      wa        <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_p      <= take & hwrite;
      wa        <= haddr[7:0];
      hrdata    <= (take && !hwrite) ? rd_val(haddr[7:0]) : 32'h0000_0000;
    end
  end

  // Configuration registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl[c] <= RST_VAL;
        sel[c]  <= '0;
        sta[c]  <= RST_VAL;
        stb[c]  <= RST_VAL;
        pad[c]  <= RST_VAL;
        cnt[c]  <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit && wc == 3'(c)) begin
          unique case (wa[RG_LSB+:3])
            R_CTRL: ctrl[c] <= hwdata[15:0] & CTRL_MASK;
            R_REQ:  sel[c] <= hwdata[SEL_W-1:0];
            R_STA:  sta[c] <= hwdata[15:0];
            R_STB:  stb[c] <= hwdata[15:0];
            R_PAD:  pad[c] <= hwdata[15:0];
            R_CNT:  cnt[c] <= hwdata[CNT_W-1:0];
            default: ;
          endcase
        end else if (off_req[c]) begin
          ctrl[c][B_EN] <= 1'b0;
        end
      end
    end
  end

  // software sets, hardware clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_b <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit && wc == 3'(c) && wa[RG_LSB+:3] == R_REQ && hwdata[B_FORCE]) begin
          force_b[c] <= 1'b1;
        end else if (force_clr[c]) begin
          force_b[c] <= 1'b0;
        end
      end
    end
  end

  // request or force makes a channel pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        pend[c] <= en[c] & ((pend[c] & ~(state == ST_IDLE && |pe && pk == 3'(c)))
                   | irq_req[sel[c]]
                   | (wr_hit && wc == 3'(c) && wa[RG_LSB+:3] == R_REQ && hwdata[B_FORCE]));
      end
    end
  end

  // Transfer sequencer: read source, capture, write destination.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      gnt       <= 3'h0;
      gforce    <= 1'b0;
      gaddr     <= 16'h0000;
      ram_addr  <= 16'h0000;
      ram_re    <= 1'b0;
      ram_we    <= 1'b0;
      ram_byte  <= 1'b0;
      ram_wdata <= 16'h0000;
      per_addr  <= 16'h0000;
      per_re    <= 1'b0;
      per_we    <= 1'b0;
      per_byte  <= 1'b0;
      per_wdata <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          ram_we <= 1'b0;
          per_we <= 1'b0;
          if (|pe) begin
            gnt      <= pk;
            gforce   <= force_b[pk];
            gaddr    <= mem_addr(pk);
            ram_byte <= ctrl[pk][B_SIZE];
            per_byte <= ctrl[pk][B_SIZE];
            if (ctrl[pk][B_DIR]) begin
              ram_re   <= 1'b1;
              ram_addr <= mem_addr(pk);
            end else begin
              per_re   <= 1'b1;
              per_addr <= pad[pk];
            end
            state <= ST_RD;
          end
        end
        ST_RD: begin
          ram_re <= 1'b0;
          per_re <= 1'b0;
          state  <= ST_CAP;
        end
        ST_CAP: begin
          if (ctrl[gnt][B_DIR]) begin
            per_we    <= 1'b1;
            per_addr  <= pad[gnt];
            per_wdata <= ctrl[gnt][B_SIZE] ? {8'h00, ram_rdata[7:0]} : ram_rdata;
          end else begin
            ram_we    <= 1'b1;
            ram_addr  <= gaddr;
            ram_wdata <= ctrl[gnt][B_SIZE] ? {8'h00, per_rdata[7:0]} : per_rdata;
          end
          state <= ST_WR;
        end
        ST_WR: begin
          ram_we <= 1'b0;
          per_we <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-channel block bookkeeping, done as the write is issued.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q      <= '0;
      pp_sel    <= '0;
      block_irq <= '0;
      off_req   <= '0;
      force_clr <= '0;
      for (int c = 0; c < NCH; c++) begin
        last_off[c] <= RST_VAL;
        nxt_off[c]  <= RST_VAL;
        done_n[c]   <= '0;
      end
    end else begin
      en_q      <= en;
      block_irq <= '0;
      off_req   <= '0;
      force_clr <= '0;
      for (int c = 0; c < NCH; c++) begin
        if (en[c] && !en_q[c]) begin
          nxt_off[c] <= sta[c];
          done_n[c]  <= '0;
          pp_sel[c]  <= 1'b0;
        end else if (state == ST_CAP && gnt == 3'(c)) begin
          logic [DONE_W-1:0] nd;
          logic [DONE_W-1:0] tot;
          logic              pp;
          logic [15:0]       nb;
          nd  = done_n[c] + 1'b1;
          tot = {1'b0, cnt[c]} + 1'b1;
          pp  = ctrl[c][MD_LSB+MD_PP];
          nb  = (pp && !pp_sel[c]) ? stb[c] : sta[c];
          last_off[c] <= gaddr;
          force_clr[c] <= gforce;
          if (ctrl[c][AM_LSB+:2] == AM_INC) begin
            nxt_off[c] <= gaddr + (ctrl[c][B_SIZE] ? STEP_BYTE : STEP_WORD);
          end
          // count plus one ends the block
          if (nd == tot) begin
            done_n[c] <= '0;
            nxt_off[c] <= nb;
            if (pp) begin
              pp_sel[c] <= ~pp_sel[c];
            end
            block_irq[c] <= ~ctrl[c][B_HALF] | (tot == 11'h001);
            off_req[c] <= ctrl[c][MD_LSB+MD_ONE] & (~pp | pp_sel[c]);
          end else begin
            done_n[c] <= nd;
            block_irq[c] <= ctrl[c][B_HALF] & (nd == (tot >> 1));
          end
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_one_direction: assert property ($onehot0({ram_we, per_we, ram_re, per_re}))
    else $error("two strobes at once");
  a_lowest_wins: assert property ((state == ST_IDLE && |pe) |=> gnt == $past(pk)
    && (($past(pe) & ((8'h01 << gnt) - 8'h01)) == 8'h00))
    else $error("grant not lowest pending");
  a_sequence_len: assert property ((state == ST_IDLE && |pe)
    |=> state == ST_RD ##1 state == ST_CAP ##1 state == ST_WR ##1 state == ST_IDLE)
    else $error("transfer sequence broken");
  a_force_clear: assert property ((state == ST_CAP && gforce) |=> ##1 !force_b[$past(gnt)])
    else $error("force bit not cleared");
  a_incr_addr: assert property ((state == ST_CAP && ctrl[gnt][AM_LSB+:2] == AM_INC
    && done_n[gnt] + 1'b1 != {1'b0, cnt[gnt]} + 1'b1) |=> nxt_off[$past(gnt)]
    == $past(gaddr) + ($past(ctrl[gnt][B_SIZE]) ? STEP_BYTE : STEP_WORD))
    else $error("address not advanced");
  a_fixed_addr: assert property ((state == ST_CAP && ctrl[gnt][AM_LSB+:2] == AM_FIX
    && done_n[gnt] != {1'b0, cnt[gnt]}) |=> $stable(nxt_off[gnt]))
    else $error("fixed address moved");
  a_indirect_addr: assert property ((state == ST_IDLE && |pe
    && ctrl[pk][AM_LSB+:2] == AM_PER)
    |=> gaddr == $past((pp_sel[pk] ? stb[pk] : sta[pk]) + ind_addr))
    else $error("indirect address not used");
  a_size_lane: assert property (ram_we |-> ram_byte == ctrl[gnt][B_SIZE]
    && (!ram_byte || ram_wdata[15:8] == 8'h00))
    else $error("byte lane wrong");
  a_irq_cause: assert property ($rose(|block_irq) |-> $past(state) == ST_CAP)
    else $error("interrupt without transfer");
  a_oneshot_off: assert property (|off_req |=> !en[$past(gnt)] || $past(wr_hit))
    else $error("one-shot channel still on");

  c_two_pending: cover property (state == ST_IDLE && $countones(pe) > 1);
  c_block_done: cover property (|block_irq && |off_req);
  c_pingpong: cover property ($rose(|pp_sel));
  c_forced: cover property (state == ST_CAP && gforce);
endmodule : mdc_dma
`default_nettype wire

// file: tb/mdc_far_model.sv
// Far-side model: peripheral data registers and the data RAM.
`timescale 1ns/100ps
`default_nettype none
module mdc_far_model #(
  parameter logic [15:0] IND_OFS = 16'h0040
) (
  // Clock
  input  wire logic        hclk,
  // Data RAM port
  input  wire logic [15:0] ram_addr,
  input  wire logic        ram_re,
  input  wire logic        ram_we,
  input  wire logic [15:0] ram_wdata,
  output logic      [15:0] ram_rdata,
  // Peripheral port
  input  wire logic [15:0] per_addr,
  input  wire logic        per_re,
  input  wire logic        per_we,
  input  wire logic [15:0] per_wdata,
  output logic      [15:0] per_rdata,
  output logic      [15:0] ind_addr
);
  logic [15:0] wa_q[$];
  logic [15:0] wd_q[$];
  logic [15:0] pa_q[$];
  logic [15:0] pd_q[$];
  assign ind_addr = IND_OFS;
  // Data stands only the cycle after a strobe; it toggles otherwise so data one cycle stale never matches.
  always @(posedge hclk) begin
    ram_rdata <= ram_re ? (ram_addr ^ 16'h3c5a) : ~ram_rdata;
    per_rdata <= per_re ? (per_addr ^ 16'ha5c3) : ~per_rdata;
    if (ram_we) begin
      wa_q.push_back(ram_addr);
      wd_q.push_back(ram_wdata);
    end
    if (per_we) begin
      pa_q.push_back(per_addr);
      pd_q.push_back(per_wdata);
    end
  end
endmodule : mdc_far_model
`default_nettype wire

// file: tb/test_multichannel_dma_controller.sv
// Self-checking bench of the multichannel transfer engine.
`timescale 1ns/100ps
`default_nettype none
module test_multichannel_dma_controller;
  import mdc_pkg::*;
  localparam logic [15:0] IND = 16'h0040;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  wire           hready;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [127:0]  irq_req;
  logic [15:0]   ind_addr, ram_addr, ram_wdata, ram_rdata;
  logic [15:0]   per_addr, per_wdata, per_rdata;
  logic          ram_re, ram_we, per_re, per_we, ram_byte, per_byte;
  logic [7:0]    block_irq;
  int            failures, n_compared;
  int            irq_n[8];
  assign hready = hreadyout;
  mdc_dma #(.NCH(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req),
    .ind_addr(ind_addr), .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we),
    .ram_byte(ram_byte), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .per_addr(per_addr),
    .per_re(per_re), .per_we(per_we), .per_byte(per_byte), .per_wdata(per_wdata),
    .per_rdata(per_rdata), .block_irq(block_irq));
  mdc_far_model #(.IND_OFS(IND)) u_far (.hclk(hclk), .ram_addr(ram_addr), .ram_re(ram_re),
    .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .per_addr(per_addr),
    .per_re(per_re), .per_we(per_we), .per_wdata(per_wdata), .per_rdata(per_rdata),
    .ind_addr(ind_addr));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    for (int i = 0; i < 8; i++) begin
      if (block_irq[i] === 1'b1) irq_n[i]++;
    end
  end
  task automatic test_done;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Waits for an edge with hready high; a bus that never answers ends the run.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input int ch, input logic [2:0] idx,
                     input logic [15:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= (32'(ch) << CH_LSB) | (32'(idx) << RG_LSB);
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'h0000, d};
    wait_rdy();
    r = hrdata;
    chk({15'h0000, hresp}, 16'h0000);
  endtask : ahb
  task automatic wr(input int ch, input logic [2:0] idx, input logic [15:0] d);
    logic [31:0] r;
    ahb(1'b1, ch, idx, d, r);
  endtask : wr
  task automatic rd_chk(input int ch, input logic [2:0] idx, input logic [15:0] e);
    logic [31:0] r;
    ahb(1'b0, ch, idx, 16'h0000, r);
    chk(r[31:16], 16'h0000);
    chk(r[15:0], e);
  endtask : rd_chk
  task automatic cfg(input int ch, input logic [15:0] ctl, sel, sta, stb, pad, cnt);
    u_far.wa_q.delete();
    u_far.wd_q.delete();
    u_far.pa_q.delete();
    u_far.pd_q.delete();
    wr(ch, R_REQ, sel);
    wr(ch, R_STA, sta);
    wr(ch, R_STB, stb);
    wr(ch, R_PAD, pad);
    wr(ch, R_CNT, cnt);
    wr(ch, R_CTRL, ctl);
  endtask : cfg
  // One request pulse, then room for the four-cycle transfer to finish.
  task automatic xfer(input int line);
    irq_req[line] <= 1'b1;
    @(posedge hclk);
    irq_req[line] <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : xfer
  task automatic s_regs;
    wr(0, R_PAD, 16'h0820);
    rd_chk(0, R_PAD, 16'h0820);
    wr(0, R_CNT, 16'h03ff);
    rd_chk(0, R_CNT, 16'h03ff);
    wr(0, R_REQ, 16'h007f);
    rd_chk(0, R_REQ, 16'h007f);
    wr(0, R_STA, 16'h0100);
    rd_chk(0, R_STA, 16'h0000);
    rd_chk(0, 3'h7, 16'h0000);
  endtask : s_regs
  task automatic s_inc;
    cfg(0, 16'h8001, 16'd11, 16'h0100, 16'h0180, 16'h0820, 16'h0002);
    repeat (4) xfer(11);
    chk(16'(u_far.wa_q.size()), 16'd3);
    for (int i = 0; i < 3; i++) begin
      chk(u_far.wa_q[i], 16'h0100 + 16'(2 * i));
      chk(u_far.wd_q[i], 16'h0820 ^ 16'ha5c3);
    end
    chk(16'(irq_n[0]), 16'd1);
    rd_chk(0, R_CTRL, 16'h0001);
    rd_chk(0, R_STA, 16'h0104);
  endtask : s_inc
  task automatic s_fix;
    cfg(1, 16'hc011, 16'd20, 16'h0150, 16'h0000, 16'h0900, 16'h0001);
    repeat (2) xfer(20);
    chk(16'(u_far.wa_q.size()), 16'd2);
    for (int i = 0; i < 2; i++) begin
      chk(u_far.wa_q[i], 16'h0150);
      chk(u_far.wd_q[i], (16'h0900 ^ 16'ha5c3) & 16'h00ff);
    end
    chk(16'(irq_n[1]), 16'd1);
    chk({15'h0000, ram_byte}, 16'h0001);
    chk({15'h0000, per_byte}, 16'h0001);
  endtask : s_fix
  task automatic s_per;
    cfg(2, 16'h8021, 16'd25, 16'h0200, 16'h0000, 16'h0a00, 16'h0000);
    xfer(25);
    chk(16'(u_far.wa_q.size()), 16'd1);
    chk(u_far.wa_q[0], 16'h0200 + IND);
    chk({15'h0000, ram_byte}, 16'h0000);
    chk({15'h0000, per_byte}, 16'h0000);
  endtask : s_per
  task automatic s_prio;
    cfg(5, 16'h8001, 16'd30, 16'h0500, 16'h0000, 16'h0a00, 16'h0000);
    wr(3, R_REQ, 16'd30);
    wr(3, R_STA, 16'h0300);
    wr(3, R_CNT, 16'h0000);
    wr(3, R_CTRL, 16'h8001);
    xfer(30);
    repeat (6) @(posedge hclk);
    chk(16'(u_far.wa_q.size()), 16'd2);
    chk(u_far.wa_q[0], 16'h0300);
    chk(u_far.wa_q[1], 16'h0500);
  endtask : s_prio
  task automatic s_force;
    cfg(4, 16'h8001, 16'd40, 16'h0400, 16'h0000, 16'h0b00, 16'h0000);
    wr(4, R_REQ, 16'h8028);
    wr(4, R_REQ, 16'h0028);
    repeat (6) @(posedge hclk);
    chk(16'(u_far.wa_q.size()), 16'd1);
    chk(u_far.wa_q[0], 16'h0400);
    rd_chk(4, R_REQ, 16'h0028);
  endtask : s_force
  task automatic s_pp;
    cfg(6, 16'h8002, 16'd50, 16'h0600, 16'h0680, 16'h0c00, 16'h0001);
    repeat (6) xfer(50);
    for (int i = 0; i < 6; i++) begin
      chk(u_far.wa_q[i], ((i / 2) % 2 ? 16'h0680 : 16'h0600) + 16'(2 * (i % 2)));
    end
    chk(16'(irq_n[6]), 16'd3);
    wr(6, R_CTRL, 16'h0000);
  endtask : s_pp
  task automatic s_half;
    cfg(7, 16'hb001, 16'd60, 16'h0700, 16'h0000, 16'h0d00, 16'h0003);
    repeat (2) xfer(60);
    chk(16'(irq_n[7]), 16'd1);
    repeat (2) xfer(60);
    chk(16'(irq_n[7]), 16'd1);
    chk(16'(u_far.wa_q.size()), 16'd0);
    chk(16'(u_far.pa_q.size()), 16'd4);
    for (int i = 0; i < 4; i++) begin
      chk(u_far.pa_q[i], 16'h0d00);
      chk(u_far.pd_q[i], (16'h0700 + 16'(2 * i)) ^ 16'h3c5a);
    end
  endtask : s_half
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    irq_req = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    s_regs();
    s_inc();
    s_fix();
    s_per();
    s_prio();
    s_force();
    s_pp();
    s_half();
    test_done();
  end
endmodule : test_multichannel_dma_controller
`default_nettype wire
